// ==== rtl/clock_synth_ctrl.sv ====
// Strap decode, output group gating and serial control byte of a clock synthesizer.
// Assumes scl and sda_in are already synchronous to mclk and the wire is resolved outside.
`timescale 1ns/1ps

// Operation
// - Frequency straps pick processor clock frequency.
// - Mode high: shared pin is 66 MHz input.
// - Mode low: internal 66 MHz, slots 33 MHz.
// - Middle level, code 00: all outputs Hi-Z.
// - Test mode divides test clock per group.
// - Test mode uses the 200 MHz dividers.
// - Power-down floats, lows outputs, stops oscillator.
// - Processor halt stops complementary processor outputs.
// - Slot halt stops only stoppable slot clocks.
// - Only block writes are accepted.
// - Bytes ascend from zero, MSB first.
// - Respond to write address byte D2h.
// - Count gives number of following data bytes.
// - Transfer valid after count acknowledge.
// - Control registers load defaults at reset.
// - Byte 0 bit 7 enables spread.
// - Byte 0 bit 5 selects 48 MHz.
// - Byte 0 bit 4 reads processor halt pin.
// - Byte 0 bits 2..0 read latched straps.
// - Straps latched once while strobe low.
module clock_synth_ctrl
  import clock_synth_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Straps.
  input wire logic [1:0] mode_strap,
  input wire logic freq_strap_hi,
  input wire logic freq_strap_lo,
  input wire logic current_multiplier_strap,
  input wire logic strap_valid_strobe_n,
  // Power management pins.
  input wire logic power_down_n,
  input wire logic cpu_halt_n,
  input wire logic slot_halt_n,
  // Serial bus pins.
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Frequency and source selection.
  output logic [1:0] cpu_freq_code,
  output logic shared_pin_is_input,
  output logic slot_from_input_half,
  output logic all_outputs_hiz,
  output logic test_clock_mode,
  output logic [3:0] ref_div,
  output logic [3:0] cpu_div,
  output logic [3:0] fixed66_div,
  output logic [3:0] slot_div,
  // Output group gating.
  output logic cpu_true_iref2,
  output logic cpu_comp_float,
  output logic cpu_comp_low,
  output logic single_ended_low,
  output logic osc_off,
  output logic stoppable_slot_run,
  output logic free_slot_run,
  // Control byte effects.
  output logic spread_enable,
  output logic shared_sel_48,
  output logic current_mult,
  output logic [7:0] control_byte0
);

  // Previous levels of the bus pins, used for edge and condition detection.
  logic scl_q, sda_q;
  // Slave state, bit counter, shift register and acknowledge drive.
  smb_state_t st_q, st_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic ack_q, ack_d;
  // Data bytes still allowed by the count, and a flag for the first data byte.
  logic [5:0] remain_q, remain_d;
  logic first_q, first_d;
  // Writable control fields.
  logic spread_q, spread_d, sel48_q, sel48_d, sw_slot_q, sw_slot_d;
  // Latched straps and the flag that closes the latch.
  logic strap_done_q, strap_done_d, mult_q, mult_d;
  logic [1:0] mode_q, mode_d, freq_q, freq_d;
  // Registered output values.
  logic [1:0] cpu_freq_d;
  logic in_mode_d, hiz_d, test_d, comp_float_d, comp_low_d, down_d, stop_run_d, free_run_d;
  logic [3:0] ref_div_d, cpu_div_d, f66_div_d, slot_div_d;
  logic [7:0] cb0_d;
  // Bus events seen from the sampled pin levels.
  logic scl_rise, scl_fall, bus_start, bus_stop, slot_halt_eff_n;
  assign scl_rise = scl && !scl_q;
  assign scl_fall = !scl && scl_q;
  assign bus_start = scl && scl_q && sda_q && !sda_in;
  assign bus_stop = scl && scl_q && !sda_q && sda_in;
  // The slot halt is active from the pin or from the software bit.
  assign slot_halt_eff_n = slot_halt_n && sw_slot_q;
  // Open-drain data line: only ever pulled low, while acknowledging.
  assign sda_out = 1'b0;
  assign sda_oe = ack_q;

  // Next state of the serial slave and of the control byte.
  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    ack_d = ack_q;
    remain_d = remain_q;
    first_d = first_q;
    spread_d = spread_q;
    sel48_d = sel48_q;
    sw_slot_d = sw_slot_q;
    if (bus_start || bus_stop) begin
      // A start begins a fresh address byte; a stop ends the transfer at any bit position.
      st_d = bus_start ? ST_ADDR : ST_IDLE;
      bit_d = 4'h0;
      ack_d = 1'b0;
    end else if (st_q != ST_IDLE) begin
      if (scl_rise && bit_q < BIT_FULL) begin
        // Bits arrive most significant first.
        sh_d = {sh_q[6:0], sda_in};
        bit_d = bit_q + 4'h1;
      end else if (scl_fall && bit_q == BIT_FULL) begin
        // A whole byte is in; decide the acknowledge for the next slot.
        bit_d = BIT_ACK;
        st_d = ST_SKIP;
        case (st_q)
          ST_ADDR: begin
            // A read direction bit is not acknowledged.
            if (sh_q == SLAVE_ADDR_WRITE) begin
              ack_d = 1'b1;
              st_d = ST_CMD;
            end
          end
          ST_CMD: begin
            // Only command code zero opens a block write.
            if (sh_q == COMMAND_CODE) begin
              ack_d = 1'b1;
              st_d = ST_COUNT;
            end
          end
          ST_COUNT: begin
            // The count limits how many data bytes are acknowledged.
            if (sh_q >= COUNT_MIN && sh_q <= COUNT_MAX) begin
              ack_d = 1'b1;
              remain_d = sh_q[5:0];
              first_d = 1'b1;
              st_d = ST_DATA;
            end
          end
          ST_DATA: begin
            if (remain_q != 6'h00) begin
              ack_d = 1'b1;
              remain_d = remain_q - 6'h01;
              first_d = 1'b0;
              st_d = ST_DATA;
              // Byte 0 is committed only now, after all eight bits.
              if (first_q) begin
                spread_d = sh_q[CB_SPREAD];
                sel48_d = sh_q[CB_SEL48];
                sw_slot_d = sh_q[CB_SLOT_HALT];
              end
            end
          end
          default: st_d = ST_SKIP;
        endcase
      end else if (scl_fall && bit_q == BIT_ACK) begin
        // The acknowledge slot ends; release the line.
        ack_d = 1'b0;
        bit_d = 4'h0;
      end
    end
  end

  // Registers of the serial slave and control byte, loaded with defaults at reset.
  always_ff @(posedge mclk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      st_q <= ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      ack_q <= 1'b0;
      remain_q <= 6'h00;
      first_q <= 1'b0;
      spread_q <= SPREAD_RST;
      sel48_q <= SEL48_RST;
      sw_slot_q <= SLOT_HALT_RST;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      ack_q <= ack_d;
      remain_q <= remain_d;
      first_q <= first_d;
      spread_q <= spread_d;
      sel48_q <= sel48_d;
      sw_slot_q <= sw_slot_d;
    end
  end

  // Strap latch: the first cycle with the strobe low captures, later ones are ignored.
  always_comb begin
    strap_done_d = strap_done_q;
    mode_d = mode_q;
    freq_d = freq_q;
    mult_d = mult_q;
    if (!strap_done_q && !strap_valid_strobe_n) begin
      strap_done_d = 1'b1;
      mode_d = mode_strap;
      freq_d = {freq_strap_hi, freq_strap_lo};
      mult_d = current_multiplier_strap;
    end
  end

  // Decode of the latched straps and the pins into the output controls.
  always_comb begin
    cpu_freq_d = freq_q;
    in_mode_d = (mode_q == MODE_HIGH);
    hiz_d = 1'b0;
    test_d = 1'b0;
    ref_div_d = DIV_NONE;
    cpu_div_d = DIV_NONE;
    f66_div_d = DIV_NONE;
    slot_div_d = DIV_NONE;
    if (mode_q == MODE_MID) begin
      if (freq_q == MID_TEST) begin
        // Test clock mode runs on the 200 MHz divider chain.
        test_d = 1'b1;
        cpu_freq_d = FREQ_200;
        ref_div_d = TEST_DIV_REF;
        cpu_div_d = TEST_DIV_CPU;
        f66_div_d = TEST_DIV_66;
        slot_div_d = TEST_DIV_SLOT;
      end else begin
        // Code 00 floats everything; the reserved codes are held floating too.
        hiz_d = 1'b1;
      end
    end
    // Power-down and the two halt inputs gate the output groups.
    down_d = !power_down_n;
    comp_float_d = !power_down_n || (!cpu_halt_n && !slot_halt_eff_n);
    comp_low_d = power_down_n && !cpu_halt_n && slot_halt_eff_n;
    stop_run_d = power_down_n && slot_halt_eff_n;
    free_run_d = power_down_n;
    // Read-back value of control byte 0; bit 6 reads zero.
    cb0_d = {spread_q, 1'b0, sel48_q, cpu_halt_n, sw_slot_q,
             (mode_q == MODE_HIGH), freq_q};
  end

  // Registers of the strap latch and of all decoded outputs.
  always_ff @(posedge mclk) begin
    if (rst) begin
      strap_done_q <= 1'b0;
      mode_q <= MODE_LOW;
      freq_q <= FREQ_66;
      mult_q <= 1'b0;
      cpu_freq_code <= FREQ_66;
      shared_pin_is_input <= 1'b0;
      slot_from_input_half <= 1'b0;
      all_outputs_hiz <= 1'b0;
      test_clock_mode <= 1'b0;
      ref_div <= DIV_NONE;
      cpu_div <= DIV_NONE;
      fixed66_div <= DIV_NONE;
      slot_div <= DIV_NONE;
      cpu_true_iref2 <= 1'b0;
      cpu_comp_float <= 1'b0;
      cpu_comp_low <= 1'b0;
      single_ended_low <= 1'b0;
      osc_off <= 1'b0;
      stoppable_slot_run <= 1'b0;
      free_slot_run <= 1'b0;
      spread_enable <= SPREAD_RST;
      shared_sel_48 <= SEL48_RST;
      current_mult <= 1'b0;
      control_byte0 <= 8'h00;
    end else begin
      strap_done_q <= strap_done_d;
      mode_q <= mode_d;
      freq_q <= freq_d;
      mult_q <= mult_d;
      cpu_freq_code <= cpu_freq_d;
      shared_pin_is_input <= in_mode_d;
      slot_from_input_half <= in_mode_d;
      all_outputs_hiz <= hiz_d;
      test_clock_mode <= test_d;
      ref_div <= ref_div_d;
      cpu_div <= cpu_div_d;
      fixed66_div <= f66_div_d;
      slot_div <= slot_div_d;
      cpu_true_iref2 <= down_d;
      cpu_comp_float <= comp_float_d;
      cpu_comp_low <= comp_low_d;
      single_ended_low <= down_d;
      osc_off <= down_d;
      stoppable_slot_run <= stop_run_d;
      free_slot_run <= free_run_d;
      spread_enable <= spread_q;
      shared_sel_48 <= sel48_q;
      current_mult <= mult_q;
      control_byte0 <= cb0_d;
    end
  end

  // Checks of the required behaviour.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_CPU_FREQ: assert property (
    (mode_q != MODE_MID) |=> (cpu_freq_code == $past(freq_q)))
    else $error("processor frequency code does not follow straps");
  AST_EXT_INPUT: assert property (
    (mode_q == MODE_HIGH) |=> (shared_pin_is_input && slot_from_input_half))
    else $error("mode high did not select the external input");
  AST_INT_66: assert property (
    (mode_q == MODE_LOW) |=> (!shared_pin_is_input && !slot_from_input_half))
    else $error("mode low did not select the internal oscillator");
  AST_HIZ: assert property (
    (mode_q == MODE_MID && freq_q == MID_HIZ) |=> all_outputs_hiz)
    else $error("outputs not floated in the high impedance mode");
  AST_TEST_DIV: assert property (
    (mode_q == MODE_MID && freq_q == MID_TEST) |=> (test_clock_mode
      && ref_div == TEST_DIV_REF && cpu_div == TEST_DIV_CPU
      && fixed66_div == TEST_DIV_66 && slot_div == TEST_DIV_SLOT))
    else $error("test clock ratios wrong");
  AST_TEST_200: assert property (
    test_clock_mode |-> (cpu_freq_code == FREQ_200))
    else $error("test mode not on the 200 MHz dividers");
  AST_PWRDN: assert property (
    !power_down_n |=> (cpu_true_iref2 && cpu_comp_float && single_ended_low
      && osc_off && !free_slot_run))
    else $error("power-down gating wrong");
  AST_CPU_HALT: assert property (
    (power_down_n && !cpu_halt_n) |=> (cpu_comp_low != cpu_comp_float))
    else $error("processor halt did not stop the complementary outputs");
  AST_SLOT_HALT: assert property (
    (power_down_n && !slot_halt_eff_n) |=> (!stoppable_slot_run && free_slot_run))
    else $error("slot halt gated the wrong clocks");
  AST_ADDR_ACK: assert property (
    (st_q == ST_ADDR && scl_fall && bit_q == BIT_FULL && sh_q == SLAVE_ADDR_WRITE
      && !bus_start && !bus_stop) |=> (sda_oe && st_q == ST_CMD))
    else $error("write address not acknowledged");
  AST_READ_NACK: assert property (
    (st_q == ST_ADDR && scl_fall && bit_q == BIT_FULL && sh_q != SLAVE_ADDR_WRITE)
      |=> !sda_oe)
    else $error("foreign or read address acknowledged");
  AST_COMMIT: assert property (
    (st_q == ST_DATA && first_q && remain_q != 6'h00 && scl_fall
      && bit_q == BIT_FULL && !bus_start && !bus_stop)
      |=> (spread_q == $past(sh_q[CB_SPREAD]) && sel48_q == $past(sh_q[CB_SEL48])))
    else $error("data byte 0 not committed");
  AST_STRAP_HOLD: assert property (
    strap_done_q |=> ($stable(mode_q) && $stable(freq_q) && $stable(mult_q)))
    else $error("latched straps changed");
  AST_READBACK: assert property (
    !rst |=> (control_byte0[4] == $past(cpu_halt_n) && control_byte0[6] == 1'b0))
    else $error("control byte read-back wrong");
  COV_BYTE0: cover property (st_q == ST_DATA && first_q && scl_fall && bit_q == BIT_FULL);
  COV_TEST: cover property (test_clock_mode);
  COV_PWRDN: cover property (cpu_true_iref2 ##1 !cpu_true_iref2);
  COV_SW_HALT: cover property (!sw_slot_q && slot_halt_n);
endmodule : clock_synth_ctrl

// ==== rtl/clock_synth_pkg.sv ====
// Constants, field positions and types of the clock synthesizer control block.
// Assumes one clock domain; every strap and pin input is synchronous to it.
package clock_synth_pkg;

  // Decoded level of the three-level mode strap.
  localparam logic [1:0] MODE_LOW = 2'h0;
  localparam logic [1:0] MODE_HIGH = 2'h1;
  localparam logic [1:0] MODE_MID = 2'h2;

  // Processor clock frequency codes, equal to the frequency strap pair.
  localparam logic [1:0] FREQ_66 = 2'h0;
  localparam logic [1:0] FREQ_100 = 2'h1;
  localparam logic [1:0] FREQ_200 = 2'h2;
  localparam logic [1:0] FREQ_133 = 2'h3;

  // Frequency strap codes of the middle mode level.
  localparam logic [1:0] MID_HIZ = 2'h0;
  localparam logic [1:0] MID_TEST = 2'h1;

  // Serial bus constants: write address byte, command code, count limits.
  localparam logic [7:0] SLAVE_ADDR_WRITE = 8'hD2;
  localparam logic [7:0] COMMAND_CODE = 8'h00;
  localparam logic [7:0] COUNT_MIN = 8'h01;
  localparam logic [7:0] COUNT_MAX = 8'h20;

  // Bit counter values: eight data bits, then the acknowledge slot.
  localparam logic [3:0] BIT_FULL = 4'h8;
  localparam logic [3:0] BIT_ACK = 4'h9;

  // Field positions in control byte 0.
  localparam int CB_SPREAD = 7;
  localparam int CB_SEL48 = 5;
  localparam int CB_SLOT_HALT = 3;

  // Reset values of the writable fields of control byte 0.
  localparam logic SPREAD_RST = 1'b0;
  localparam logic SEL48_RST = 1'b0;
  localparam logic SLOT_HALT_RST = 1'b1;

  // Test clock division ratios per output group; zero means not in test mode.
  localparam logic [3:0] DIV_NONE = 4'h0;
  localparam logic [3:0] TEST_DIV_REF = 4'h1;
  localparam logic [3:0] TEST_DIV_CPU = 4'h2;
  localparam logic [3:0] TEST_DIV_66 = 4'h4;
  localparam logic [3:0] TEST_DIV_SLOT = 4'h8;

  // States of the serial bus slave.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_COUNT,
    ST_DATA,
    ST_SKIP
  } smb_state_t;

endpackage : clock_synth_pkg

// ==== tb/smbus_host_model.sv ====
// Host controller model that issues block writes byte by byte on the serial bus.
// Assumes sda_line is the resolved data wire with a pull-up, and scl idles high.
`timescale 1ns/1ps
module smbus_host_model (
  // Clock.
  input wire logic mclk,
  // Bus wires.
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  // Both lines start released, so the bus idles high.
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // Waits the given number of rising clock edges.
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  // Start condition: data falls while the clock is high.
  task automatic bus_start();
    sda_drv <= 1'b1;
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b0;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask : bus_start

  // Sends one byte and returns the acknowledge read in the ninth clock.
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_drv <= b[i];
      tick(2);
      scl <= 1'b1;
      tick(4);
      scl <= 1'b0;
      tick(2);
    end
    // Release data so the device can pull it low.
    sda_drv <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(2);
    ack = ~sda_line;
    tick(2);
    scl <= 1'b0;
    tick(2);
  endtask : send_byte

  // Stop condition: data rises while the clock is high.
  task automatic bus_stop();
    sda_drv <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b1;
    tick(4);
  endtask : bus_stop
endmodule : smbus_host_model

// ==== tb/clock_synth_ctrl_tb.sv ====
// Self-checking bench for the strap decode, gating and serial control byte.
// Assumes the host model drives scl and data; the wire is resolved here.
`timescale 1ns/1ps
module clock_synth_ctrl_tb;
  import clock_synth_pkg::*;
  // Stimulus and observed signals.
  logic mclk, rst, freq_strap_hi, freq_strap_lo, current_multiplier_strap;
  logic [1:0] mode_strap;
  logic strap_valid_strobe_n, power_down_n, cpu_halt_n, slot_halt_n;
  logic scl, sda_drv, sda_out, sda_oe, shared_pin_is_input, slot_from_input_half;
  logic [1:0] cpu_freq_code;
  logic all_outputs_hiz, test_clock_mode, cpu_true_iref2, cpu_comp_float, cpu_comp_low;
  logic [3:0] ref_div, cpu_div, fixed66_div, slot_div;
  logic single_ended_low, osc_off, stoppable_slot_run, free_slot_run;
  logic spread_enable, shared_sel_48, current_mult;
  logic [7:0] control_byte0;
  int checked = 0;
  int bad_count = 0;
  // Strap cases: mode level and frequency code.
  int mode_tab [8] = '{0, 0, 0, 0, 1, 2, 2, 2};
  int code_tab [8] = '{0, 1, 2, 3, 2, 0, 1, 3};
  // The wire is pulled up; the device only ever pulls it low.
  wire sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);

  clock_synth_ctrl u_dut (.mclk(mclk), .rst(rst), .mode_strap(mode_strap),
    .freq_strap_hi(freq_strap_hi), .freq_strap_lo(freq_strap_lo),
    .current_multiplier_strap(current_multiplier_strap),
    .strap_valid_strobe_n(strap_valid_strobe_n), .power_down_n(power_down_n),
    .cpu_halt_n(cpu_halt_n), .slot_halt_n(slot_halt_n), .scl(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .cpu_freq_code(cpu_freq_code),
    .shared_pin_is_input(shared_pin_is_input), .slot_from_input_half(slot_from_input_half),
    .all_outputs_hiz(all_outputs_hiz), .test_clock_mode(test_clock_mode),
    .ref_div(ref_div), .cpu_div(cpu_div), .fixed66_div(fixed66_div), .slot_div(slot_div),
    .cpu_true_iref2(cpu_true_iref2), .cpu_comp_float(cpu_comp_float),
    .cpu_comp_low(cpu_comp_low), .single_ended_low(single_ended_low), .osc_off(osc_off),
    .stoppable_slot_run(stoppable_slot_run), .free_slot_run(free_slot_run),
    .spread_enable(spread_enable), .shared_sel_48(shared_sel_48),
    .current_mult(current_mult), .control_byte0(control_byte0));

  smbus_host_model u_host (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

  // Clock of 8 ns period.
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Compares a result and counts any mismatch.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  // Holds reset for four edges, then lets two edges pass: outputs are read just as an
  // edge arrives, so they show what the previous edge stored.
  task automatic do_reset();
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : do_reset

  // Strobes the straps, then changes them while the strobe is still low.
  task automatic latch(input logic [1:0] m, input logic [1:0] c, input logic k);
    mode_strap <= m;
    freq_strap_hi <= c[1];
    freq_strap_lo <= c[0];
    current_multiplier_strap <= k;
    strap_valid_strobe_n <= 1'b0;
    @(posedge mclk);
    mode_strap <= ~m;
    freq_strap_hi <= ~c[1];
    freq_strap_lo <= ~c[0];
    current_multiplier_strap <= ~k;
    repeat (2) @(posedge mclk);
    strap_valid_strobe_n <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask : latch

  // One framed transfer of k bytes; checks acks and the control byte effects.
  task automatic blk(input logic [7:0] a, c, n, d0, d1, d2, input int k,
                     input logic [5:0] ea, input logic [7:0] eb);
    logic [7:0] b [6];
    logic [5:0] acks;
    logic ack;
    b = '{a, c, n, d0, d1, d2};
    acks = '0;
    u_host.bus_start();
    for (int i = 0; i < k; i++) begin
      u_host.send_byte(b[i], ack);
      acks[i] = ack;
    end
    u_host.bus_stop();
    chk(8'(acks), 8'(ea));
    chk(control_byte0, eb);
    chk(8'({spread_enable, shared_sel_48, stoppable_slot_run}),
        8'({eb[7], eb[5], eb[3]}));
  endtask : blk

  // Cuts a hang short.
  initial begin
    repeat (50000) @(posedge mclk);
    bad_count++;
    finish_test();
  end

  // Main sequence.
  initial begin
    logic [1:0] m, c;
    logic tst;
    rst = 1'b1;
    mode_strap = MODE_LOW;
    freq_strap_hi = 1'b0;
    freq_strap_lo = 1'b0;
    current_multiplier_strap = 1'b0;
    strap_valid_strobe_n = 1'b1;
    power_down_n = 1'b1;
    cpu_halt_n = 1'b1;
    slot_halt_n = 1'b1;
    @(posedge mclk);
    // Eight strap settings (all codes at mode low, code 2 at mode high, codes 0, 1, 3 at middle), each after a fresh reset.
    for (int i = 0; i < 8; i++) begin
      m = 2'(mode_tab[i]);
      c = 2'(code_tab[i]);
      tst = (m == MODE_MID) && (c == MID_TEST);
      do_reset();
      chk(control_byte0, 8'h18);
      latch(m, c, i[0]);
      chk(control_byte0, {5'h03, m == MODE_HIGH, c});
      if (m != MODE_MID || tst) begin
        chk(8'(cpu_freq_code), 8'(tst ? FREQ_200 : c));
      end
      chk(8'({shared_pin_is_input, slot_from_input_half}),
          8'({2{m == MODE_HIGH}}));
      chk(8'({all_outputs_hiz, test_clock_mode, current_mult}),
          8'({m == MODE_MID && !tst, tst, i[0]}));
      chk({ref_div, cpu_div}, tst ? {TEST_DIV_REF, TEST_DIV_CPU} : 8'h00);
      chk({fixed66_div, slot_div}, tst ? {TEST_DIV_66, TEST_DIV_SLOT} : 8'h00);
    end
    do_reset();
    latch(MODE_LOW, 2'h0, 1'b0);
    // Every combination of the power-down and halt pins.
    for (int j = 0; j < 8; j++) begin
      power_down_n <= j[2];
      cpu_halt_n <= j[1];
      slot_halt_n <= j[0];
      repeat (3) @(posedge mclk);
      chk({cpu_true_iref2, single_ended_low, osc_off, cpu_comp_float, cpu_comp_low,
           stoppable_slot_run, free_slot_run, control_byte0[4]},
          {{3{~j[2]}}, ~j[2] | (~j[1] & ~j[0]), j[2] & ~j[1] & j[0], j[2] & j[0],
           j[2], j[1]});
    end
    // Serial writes: good, refused, boundary and over-long transfers.
    blk(8'hD2, 8'h00, 8'h01, 8'hA0, 8'h00, 8'h00, 4, 6'h0F, 8'hB0);
    blk(8'hD3, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 4, 6'h00, 8'hB0);
    blk(8'hD2, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 4, 6'h01, 8'hB0);
    blk(8'hD2, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 4, 6'h03, 8'hB0);
    blk(8'hD2, 8'h00, 8'h21, 8'h00, 8'h00, 8'h00, 4, 6'h03, 8'hB0);
    blk(8'hD2, 8'h00, 8'h20, 8'h08, 8'hFF, 8'hFF, 6, 6'h3F, 8'h18);
    blk(8'hD2, 8'h00, 8'h02, 8'h00, 8'h55, 8'hAA, 6, 6'h1F, 8'h10);
    // A reset restores the defaults of the written fields.
    do_reset();
    chk(control_byte0, 8'h18);
    chk(8'({spread_enable, shared_sel_48, stoppable_slot_run}), 8'h01);
    finish_test();
  end
endmodule : clock_synth_ctrl_tb
